// *** hdl/chv_pkg.sv ***
// Types shared by the voltage limit register bank
package chv_pkg;

  // ==========================================
  // Boot sequence states
  typedef enum logic [2:0] {
    CHV_ST_WAIT = 3'b001,
    CHV_ST_LOAD = 3'b010,
    CHV_ST_RUN  = 3'b100
  } chv_boot_e;

  // Eight-bit setting code
  typedef logic [7:0] chv_code_t;

endpackage

// *** hdl/chv_regbank.sv ***
// Voltage limit setting registers of the charge controller
`timescale 1ns/1ps
`default_nettype none
`include "chv_regs.svh"

module chv_regbank
  import chv_pkg::*;
#(
  parameter int MV_W = 16
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            smb_wr_i,
  input  wire logic            smb_rd_i,
  input  wire logic [7:0]      smb_cmd_i,
  input  wire logic [15:0]     smb_wdata_i,
  input  wire logic [1:0]      cell_count_select_pin_i,
  input  wire logic [MV_W-1:0] vbus_mv_i,
  output logic      [15:0]     smb_rdata_o,
  output logic                 smb_rvalid_o,
  output logic                 smb_wack_o,
  output logic                 smb_reject_o,
  output logic      [7:0]      otg_current_limit_o,
  output logic      [7:0]      min_system_voltage_o,
  output logic      [MV_W-1:0] input_voltage_regulation_mv_o,
  output logic                 input_voltage_regulation_o
);

  // ==========================================
  // Parameter check
  if (MV_W < 15) begin : g_chk
    $error("chv_regbank: MV_W too small for 19520 mV");
  end

  // Ordered range window, or every nonzero minimum system write would be refused
  if (`CHV_VSYS_CODE_MIN > `CHV_VSYS_CODE_MAX) begin : g_chk_range
    $error("chv_regbank: minimum system range is empty");
  end

  // ==========================================
  // Reset release
  logic rst_q1;
  logic rst_q2;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  // Assertion stays asynchronous, so outputs take their reset values even with the clock stopped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Internal active-low reset for every other process
  assign rst_n = rst_q2;

  // ==========================================
  // Pin synchronisers
  logic [1:0]      cell_q1;
  logic [1:0]      cell_q2;
  logic [MV_W-1:0] vbus_q1;
  logic [MV_W-1:0] vbus_q2;

  // Strap pin and measured bus both come from outside the clock domain
  // The bus reading moves slowly; a torn word after a step lasts one cycle
  // and can nudge the unprogrammed threshold or the programmed regulation flag
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cell_q1 <= 2'h0;
      cell_q2 <= 2'h0;
      vbus_q1 <= '0;
      vbus_q2 <= '0;
    end else begin
      cell_q1 <= cell_count_select_pin_i;
      cell_q2 <= cell_q1;
      vbus_q1 <= vbus_mv_i;
      vbus_q2 <= vbus_q1;
    end
  end

  // ==========================================
  // Default lookup
  // Pin codes 0 to 3 pick one to four cells; result in 100 mV units
  function automatic chv_code_t vsys_default(input logic [1:0] cells);
    chv_code_t d;
    case (cells)
      2'h0:    d = `CHV_VSYS_DEF_1S;
      2'h1:    d = `CHV_VSYS_DEF_2S;
      2'h2:    d = `CHV_VSYS_DEF_3S;
      default: d = `CHV_VSYS_DEF_4S;
    endcase
    return d;
  endfunction

  // ==========================================
  // Boot sequence: let the strap settle, then load the default
  // The synchroniser shows the pin two cycles after reset; the wait covers it.
  // Writes stay refused until the load, so a late strap load never
  // overwrites a host setting.
  chv_boot_e boot_q;
  logic [1:0] boot_cnt_q;

  // Boot state machine
  // Three wait cycles, one load cycle, then run until the next reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_q     <= CHV_ST_WAIT;
      boot_cnt_q <= 2'h0;
    end else begin
      case (boot_q)
        CHV_ST_WAIT: begin
          boot_cnt_q <= boot_cnt_q + 2'h1;
          if (boot_cnt_q == `CHV_BOOT_WAIT) begin
            boot_q <= CHV_ST_LOAD;
          end
        end
        CHV_ST_LOAD: begin
          boot_q <= CHV_ST_RUN;
        end
        CHV_ST_RUN: begin
          boot_q <= CHV_ST_RUN;
        end
        default: begin
          boot_q <= CHV_ST_WAIT;
        end
      endcase
    end
  end

  // Host writes are taken only once the boot has finished
  logic running;
  assign running = (boot_q == CHV_ST_RUN);

  // ==========================================
  // Write decode
  logic      wr_otg;
  logic      wr_vin;
  logic      wr_vsys;
  logic      vin_rsv_set;
  chv_code_t vsys_code;
  logic      vsys_zero;
  logic      vsys_in_range;
  logic      wr_ok;
  logic      wr_bad;

  // Whole-word write strobes per command code
  assign wr_otg  = smb_wr_i && running && (smb_cmd_i == `CHV_CMD_OTG_CUR);
  assign wr_vin  = smb_wr_i && running && (smb_cmd_i == `CHV_CMD_VIN_LIM);
  assign wr_vsys = smb_wr_i && running && (smb_cmd_i == `CHV_CMD_MIN_SYS);

  // Reserved-high check on the input limit
  // Data checks run every cycle; only a strobe for their own code uses them
  assign vin_rsv_set = |smb_wdata_i[`CHV_VIN_RSV_HI:`CHV_VIN_RSV_LO];

  // Minimum system code and its legal window
  assign vsys_code     = smb_wdata_i[`CHV_VSYS_HI:`CHV_VSYS_LO];
  assign vsys_zero     = (vsys_code == 8'h00);
  assign vsys_in_range = (vsys_code >= `CHV_VSYS_CODE_MIN) &&
                         (vsys_code <= `CHV_VSYS_CODE_MAX);

  // Accepted and refused writes
  // Unmapped codes and writes during boot fall through to a refusal
  assign wr_ok  = wr_otg || (wr_vin && !vin_rsv_set) ||
                  (wr_vsys && (vsys_zero || vsys_in_range));
  assign wr_bad = smb_wr_i && !wr_ok;

  // ==========================================
  // Setting registers
  chv_code_t otg_q;
  chv_code_t vin_q;
  logic      vin_prog_q;
  chv_code_t vsys_q;

  // Current limit upper byte; low byte never stored
  // Bit 15 is kept as written; a write to this code is refused only during the boot
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      otg_q <= `CHV_OTG_RESET;
    end else if (wr_otg) begin
      otg_q <= smb_wdata_i[`CHV_OTG_HI:`CHV_OTG_LO];
    end
  end

  // Input limit code and programmed mark
  // A refused word leaves both the code and the mark untouched
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vin_q      <= `CHV_VIN_RESET;
      vin_prog_q <= 1'b0;
    end else if (wr_vin && !vin_rsv_set) begin
      vin_q      <= smb_wdata_i[`CHV_VIN_HI:`CHV_VIN_LO];
      vin_prog_q <= 1'b1;
    end
  end

  // Minimum system voltage: strap default, zero restore, range filter
  // The strap load happens once, inside the boot window, so it never races
  // a host write; a zero write reads the synchronised pin at that moment
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vsys_q <= `CHV_VSYS_RESET;
    end else if (boot_q == CHV_ST_LOAD) begin
      vsys_q <= vsys_default(cell_q2);
    end else if (wr_vsys && vsys_zero) begin
      vsys_q <= vsys_default(cell_q2);
    end else if (wr_vsys && vsys_in_range) begin
      vsys_q <= vsys_code;
    end
  end

  // ==========================================
  // Write answer pulses
  // One of the two pulses follows each write strobe once out of reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      smb_wack_o   <= 1'b0;
      smb_reject_o <= 1'b0;
    end else begin
      smb_wack_o   <= wr_ok;
      smb_reject_o <= wr_bad;
    end
  end

  // ==========================================
  // Read path
  logic [15:0] rd_d;

  // Word read mux; unmapped codes read zero
  // Bits outside the stored fields read zero, whatever was written
  always_comb begin
    case (smb_cmd_i)
      `CHV_CMD_OTG_CUR:  rd_d = {otg_q, 8'h00};
      `CHV_CMD_VIN_LIM:  rd_d = {2'h0, vin_q, 6'h00};
      `CHV_CMD_MIN_SYS:  rd_d = {vsys_q, 8'h00};
      default:           rd_d = 16'h0000;
    endcase
  end

  // Registered read answer
  // Read data holds until the next read, so a slow host may take it late
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      smb_rdata_o  <= 16'h0000;
      smb_rvalid_o <= 1'b0;
    end else begin
      smb_rvalid_o <= smb_rd_i;
      if (smb_rd_i) begin
        smb_rdata_o <= rd_d;
      end
    end
  end

  // ==========================================
  // Setting outputs
  // Registered copies, so each output leaves straight from a flip-flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      otg_current_limit_o  <= `CHV_OTG_RESET;
      min_system_voltage_o <= `CHV_VSYS_RESET;
    end else begin
      otg_current_limit_o  <= otg_q;
      min_system_voltage_o <= vsys_q;
    end
  end

  // ==========================================
  // Regulation threshold and comparator
  // Fed the synchronised bus reading and the stored code; registered inside
  chv_vin_reg #(
    .MV_W (MV_W)
  ) u_vin_reg (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n),
    .code_i         (vin_q),
    .programmed_i   (vin_prog_q),
    .vbus_mv_i      (vbus_q2),
    .threshold_mv_o (input_voltage_regulation_mv_o),
    .regulating_o   (input_voltage_regulation_o)
  );

endmodule

`default_nettype wire

// *** hdl/chv_regs.svh ***
// Register offsets, field positions, reset values and scale constants
`ifndef CHV_REGS_SVH
`define CHV_REGS_SVH

// ==========================================
// Command codes
`define CHV_CMD_OTG_CUR    8'h3c
`define CHV_CMD_VIN_LIM    8'h3d
`define CHV_CMD_MIN_SYS    8'h3e

// ==========================================
// Field positions
`define CHV_OTG_HI         15
`define CHV_OTG_LO         8
`define CHV_VIN_RSV_HI     15
`define CHV_VIN_RSV_LO     14
`define CHV_VIN_HI         13
`define CHV_VIN_LO         6
`define CHV_VSYS_HI        15
`define CHV_VSYS_LO        8

// ==========================================
// Reset values
`define CHV_OTG_RESET      8'h3c
`define CHV_VIN_RESET      8'h00
`define CHV_VSYS_RESET     8'h24

// ==========================================
// Scale and range
`define CHV_VIN_OFFSET_MV  16'h0c80
`define CHV_VIN_DROP_MV    16'h0500
`define CHV_VIN_STEP_SHIFT 6
`define CHV_VSYS_CODE_MIN  8'h0a
`define CHV_VSYS_CODE_MAX  8'hc0
`define CHV_VSYS_DEF_1S    8'h24
`define CHV_VSYS_DEF_2S    8'h42
`define CHV_VSYS_DEF_3S    8'h5c
`define CHV_VSYS_DEF_4S    8'h7b

// ==========================================
// Timing
`define CHV_BOOT_WAIT      2'h2

`endif

// *** hdl/chv_vin_reg.sv ***
// Input voltage regulation threshold and comparator
`timescale 1ns/1ps
`default_nettype none
`include "chv_regs.svh"

module chv_vin_reg
  import chv_pkg::*;
#(
  parameter int MV_W = 16
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire chv_code_t       code_i,
  input  wire logic            programmed_i,
  input  wire logic [MV_W-1:0] vbus_mv_i,
  output logic      [MV_W-1:0] threshold_mv_o,
  output logic                 regulating_o
);

  // ==========================================
  // Parameter check
  if (MV_W < 15) begin : g_chk
    $error("chv_vin_reg: MV_W too small for 19520 mV");
  end

  logic [MV_W-1:0] thr_d;
  logic [MV_W-1:0] weighted;

  // Weighted code plus fixed offset, or drop below unloaded bus
  always_comb begin
    weighted = MV_W'({code_i, 6'h00});
    if (programmed_i) begin
      thr_d = weighted + MV_W'(`CHV_VIN_OFFSET_MV);
    end else if (vbus_mv_i > MV_W'(`CHV_VIN_DROP_MV)) begin
      thr_d = vbus_mv_i - MV_W'(`CHV_VIN_DROP_MV);
    end else begin
      thr_d = '0;
    end
  end

  // Threshold register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      threshold_mv_o <= '0;
    end else begin
      threshold_mv_o <= thr_d;
    end
  end

  // Regulation flag: bus sagged below the programmed threshold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulating_o <= 1'b0;
    end else begin
      regulating_o <= programmed_i && (vbus_mv_i < threshold_mv_o);
    end
  end

endmodule

`default_nettype wire

// *** tb/charger_voltage_limit_regs_test.sv ***
// Self-checking bench for the voltage limit register bank
`timescale 1ns/1ps
`default_nettype none
module charger_voltage_limit_regs_test;
  logic        clk_i;
  logic        rst_n_i;
  logic [1:0]  pin;
  logic [15:0] vbus;
  logic        wr;
  logic        rd;
  logic [7:0]  cmd;
  logic [15:0] wd;
  logic [15:0] rdata;
  logic        rvalid;
  logic        wack;
  logic        rej;
  logic [15:0] thr;
  logic        flag;
  logic [7:0]  otg;
  logic [7:0]  msys;
  logic [15:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [31:0] seed = 32'hb9202983;
  logic [15:0] d;
  logic [7:0]  last;
  int          fail_count;
  int          n_compared;
  logic [7:0]  vc[6] = '{8'h01, 8'h09, 8'h0a, 8'hc0, 8'hc1, 8'hff};
  logic [7:0]  dflt[4] = '{8'h24, 8'h42, 8'h5c, 8'h7b};

  chv_host host (.clk_i, .smb_wr_o(wr), .smb_rd_o(rd), .smb_cmd_o(cmd), .smb_wdata_o(wd));
  chv_regbank #(.MV_W(16)) dut (.clk_i, .rst_n_i, .smb_wr_i(wr), .smb_rd_i(rd), .smb_cmd_i(cmd),
    .smb_wdata_i(wd), .cell_count_select_pin_i(pin), .vbus_mv_i(vbus), .smb_rdata_o(rdata),
    .smb_rvalid_o(rvalid), .smb_wack_o(wack), .smb_reject_o(rej), .otg_current_limit_o(otg),
    .min_system_voltage_o(msys), .input_voltage_regulation_mv_o(thr),
    .input_voltage_regulation_o(flag));

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_w(input logic [7:0] c, input logic [15:0] v, input logic ok);
    wr_q.push_back({ok, !ok});
    host.xfer(1'b1, c, v);
  endtask
  task automatic rd_w(input logic [7:0] c, input logic [15:0] e);
    rd_q.push_back(e);
    host.xfer(1'b0, c, 16'h0000);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // Clock, monitor and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Oldest note is compared whenever an answer shows
  always @(posedge clk_i) begin
    #1;
    if (rvalid === 1'b1) check("read data", rdata, rd_q.pop_front());
    if ((wack | rej) === 1'b1) check("write answer", {wack, rej}, wr_q.pop_front());
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end

  // ==========================================
  // Scenarios
  initial begin
    rst_n_i = 1'b0;
    pin = 2'h2;
    vbus = 16'd12000;
    last = 8'h5c;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    #1;
    check("threshold", thr, 16'd10720);
    check("flag", {15'h0, flag}, 16'h0);
    rd_w(8'h3c, 16'h3c00);
    rd_w(8'h3d, 16'h0000);
    rd_w(8'h3e, 16'h5c00);
    for (int i = 0; i < 4; i++) begin
      d = 16'(rnd()) & 16'h7fff;
      wr_w(8'h3c, d, 1'b1);
      rd_w(8'h3c, {d[15:8], 8'h00});
      #1;
      check("otg limit", {8'h00, otg}, {8'h00, d[15:8]});
    end
    wr_w(8'h3d, 16'h103f, 1'b1);
    rd_w(8'h3d, 16'h1000);
    #1;
    check("threshold", thr, 16'd7296);
    vbus <= 16'd5000;
    repeat (6) @(posedge clk_i);
    #1;
    check("flag", {15'h0, flag}, 16'h1);
    vbus <= 16'd7297 + 16'(rnd() % 8000);
    repeat (6) @(posedge clk_i);
    #1;
    check("flag", {15'h0, flag}, 16'h0);
    wr_w(8'h3d, 16'h4000, 1'b0);
    wr_w(8'h3d, 16'h8fc0, 1'b0);
    rd_w(8'h3d, 16'h1000);
    wr_w(8'h40, 16'h1234, 1'b0);
    rd_w(8'h40, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      d = {vc[i], 8'(rnd())};
      wr_w(8'h3e, d, i == 2 || i == 3);
      if (i == 2 || i == 3) last = vc[i];
      rd_w(8'h3e, {last, 8'h00});
      #1;
      check("min system", {8'h00, msys}, {8'h00, last});
    end
    for (int p = 0; p < 4; p++) begin
      pin <= 2'(p);
      repeat (4) @(posedge clk_i);
      wr_w(8'h3e, 16'h0000, 1'b1);
      rd_w(8'h3e, {dflt[p], 8'h00});
      #1;
      check("min system", {8'h00, msys}, {8'h00, dflt[p]});
    end
    // Mid-run reset: power-on values return and a write during the boot is refused
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1;
    check("reset threshold", thr, 16'h0000);
    check("reset otg", {8'h00, otg}, 16'h003c);
    check("reset min system", {8'h00, msys}, 16'h0024);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wr_w(8'h3e, 16'h5000, 1'b0);
    repeat (4) @(posedge clk_i);
    rd_w(8'h3e, 16'h7b00);
    rd_w(8'h3d, 16'h0000);
    rd_w(8'h3c, 16'h3c00);
    #1;
    check("threshold", thr, vbus - 16'd1280);
    check("flag", {15'h0, flag}, 16'h0);
    repeat (3) @(posedge clk_i);
    check("pending", 16'(rd_q.size() + wr_q.size()), 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire

// *** tb/chv_host.sv ***
// SMBus host model issuing whole-word reads and writes
`timescale 1ns/1ps
`default_nettype none
module chv_host (
  input  wire logic   clk_i,
  output logic        smb_wr_o,
  output logic        smb_rd_o,
  output logic [7:0]  smb_cmd_o,
  output logic [15:0] smb_wdata_o
);
  // Idle bus at power-up
  initial begin
    smb_wr_o = 1'b0;
    smb_rd_o = 1'b0;
    smb_cmd_o = 8'h00;
    smb_wdata_o = 16'h0000;
  end
  // One strobe cycle per whole word, then released
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk_i);
    smb_wr_o <= wr;
    smb_rd_o <= !wr;
    smb_cmd_o <= cmd;
    smb_wdata_o <= data;
    @(posedge clk_i);
    smb_wr_o <= 1'b0;
    smb_rd_o <= 1'b0;
    smb_cmd_o <= ~cmd;
    smb_wdata_o <= ~data;
  endtask
endmodule
`default_nettype wire

// *** tb/chv_regbank_properties.sv ***
// Port checks for the voltage limit register bank
`timescale 1ns/1ps
`default_nettype none
module chv_regbank_chk #(
  parameter int MV_W = 16
) (
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  input wire logic            smb_wr_i,
  input wire logic            smb_rd_i,
  input wire logic [7:0]      smb_cmd_i,
  input wire logic [15:0]     smb_wdata_i,
  input wire logic [1:0]      cell_count_select_pin_i,
  input wire logic            smb_rvalid_o,
  input wire logic            smb_wack_o,
  input wire logic            smb_reject_o,
  input wire logic [7:0]      otg_current_limit_o,
  input wire logic [7:0]      min_system_voltage_o,
  input wire logic [MV_W-1:0] input_voltage_regulation_mv_o
);
  logic [7:0] code;
  logic       wr_vs;
  logic       bad_vs;
  logic [7:0] dflt;

  // ==========================================
  // Helpers
  assign code   = smb_wdata_i[15:8];
  assign wr_vs  = smb_wr_i && smb_cmd_i == 8'h3e;
  assign bad_vs = wr_vs && code != 8'h00 && (code < 8'h0a || code > 8'hc0);
  // Strap default per cell count
  always_comb begin
    case (cell_count_select_pin_i)
      2'h0: dflt = 8'h24;
      2'h1: dflt = 8'h42;
      2'h2: dflt = 8'h5c;
      default: dflt = 8'h7b;
    endcase
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================
  // Assertions
  AST_RD_LAT: assert property (smb_rd_i |=> smb_rvalid_o)
    else $error("read answer missing");
  AST_WR_ONE: assert property (smb_wr_i |=> smb_wack_o != smb_reject_o)
    else $error("write answer not exactly one of ack and reject");
  AST_VIN_RSV: assert property (smb_wr_i && smb_cmd_i == 8'h3d && |smb_wdata_i[15:14]
    |=> smb_reject_o) else $error("reserved input limit bits accepted");
  AST_VS_RANGE: assert property (bad_vs |=> smb_reject_o ##1 $stable(min_system_voltage_o))
    else $error("out of range minimum system write taken");
  AST_VS_TAKE: assert property (wr_vs && code != 8'h00 ##1 smb_wack_o
    |=> min_system_voltage_o == $past(smb_wdata_i[15:8], 2)) else $error("vsys code not stored");
  AST_VS_ZERO: assert property (wr_vs && code == 8'h00 ##1 smb_wack_o
    |=> min_system_voltage_o == dflt) else $error("zero write did not restore strap default");
  AST_OTG_TAKE: assert property (smb_wr_i && smb_cmd_i == 8'h3c ##1 smb_wack_o
    |=> otg_current_limit_o == $past(smb_wdata_i[15:8], 2)) else $error("otg high byte wrong");
  AST_VIN_THR: assert property (smb_wr_i && smb_cmd_i == 8'h3d ##1 smb_wack_o
    |=> input_voltage_regulation_mv_o == 3200 + 64 * $past(smb_wdata_i[13:6], 2))
    else $error("threshold not offset plus weighted code");
  // Main scenarios reached
  cover property (smb_rd_i ##1 smb_rvalid_o);
  cover property (bad_vs ##1 smb_reject_o);
  cover property (smb_wr_i && smb_cmd_i == 8'h3d ##1 smb_wack_o);
endmodule
bind chv_regbank chv_regbank_chk #(.MV_W(MV_W)) u_chk (.clk_i, .rst_n_i, .smb_wr_i, .smb_rd_i,
  .smb_cmd_i, .smb_wdata_i, .cell_count_select_pin_i, .smb_rvalid_o, .smb_wack_o, .smb_reject_o,
  .otg_current_limit_o, .min_system_voltage_o, .input_voltage_regulation_mv_o);
`default_nettype wire
